// *** cad_map.svh ***
// Register map, field positions, reset values and timing counts
`ifndef CAD_MAP_SVH
`define CAD_MAP_SVH
// Register indices; byte address is four times the index
`define CAD_IDX_PWR       8'h08
`define CAD_IDX_MICB      8'h4a
`define CAD_IDX_JACK      8'h4d
`define CAD_IDX_APOP      8'h4e
`define CAD_IDX_STS       8'h60
`define CAD_IDX_MSK       8'h61
`define CAD_IDX_RAW       8'h62
`define CAD_IDX_CFG       8'h63
// Field positions
`define CAD_JACK_L_BIT    15
`define CAD_JACK_R_BIT    14
`define CAD_PWR_MIC_BIT   8
`define CAD_MICB_MIC_BIT  7
`define CAD_PLUG_HI       4
`define CAD_PLUG_LO       2
`define CAD_SHORT_HI      1
`define CAD_SHORT_LO      0
`define CAD_STR_BIT       2
`define CAD_SEL_HI        1
`define CAD_SEL_LO        0
`define CAD_APOP_HI       9
`define CAD_APOP_LO       8
`define CAD_CFG_SLOW_BIT  0
// Writable bits per register
`define CAD_PWR_WMASK     16'h0007
`define CAD_MICB_WMASK    16'h001f
`define CAD_JACK_WMASK    16'hc000
`define CAD_APOP_WMASK    16'h0300
`define CAD_CFG_WMASK     16'h0001
`define CAD_RST_REG       16'h0000
// Timing
`define CAD_CLK_NS        50
`define CAD_SLOW_NS       30518
`define CAD_SLOW_CYC      (`CAD_SLOW_NS / `CAD_CLK_NS)
`define CAD_RAMP_FAST_NS  1000
`define CAD_RAMP_MED_NS   4000
`define CAD_RAMP_SLOW_NS  16000
`define CAD_RAMP_FAST_CYC (`CAD_RAMP_FAST_NS / `CAD_CLK_NS)
`define CAD_RAMP_MED_CYC  (`CAD_RAMP_MED_NS / `CAD_CLK_NS)
`define CAD_RAMP_SLOW_CYC (`CAD_RAMP_SLOW_NS / `CAD_CLK_NS)
`endif

// *** cad_pkg.sv ***
// Shared types for the accessory detect block
package cad_pkg;
    typedef struct packed {
        logic mic_short;
        logic mic_plug;
        logic jack_r;
        logic jack_l;
    } cad_sense_t;

    typedef enum logic [1:0] {
        RAMP_HOLD,
        RAMP_RISE,
        RAMP_FALL
    } cad_ramp_st_t;
endpackage

// *** cad_sync.sv ***
// Two-stage synchroniser for the comparator outputs
`timescale 1ns/1ps
module cad_sync
    import cad_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire cad_sense_t d_i,
    output cad_sense_t      q_o
);
    cad_sense_t meta_reg;
    cad_sense_t q_reg;

    // First stage feeds only the second
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= d_i;
            q_reg    <= meta_reg;
        end
    end

    assign q_o = q_reg;
endmodule

// *** cad_ramp.sv ***
// Soft ramp of the mid-rail reference level
`timescale 1ns/1ps
`include "cad_map.svh"
module cad_ramp
    import cad_pkg::*;
#(
    parameter int LVL_W = 8
) (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             on_i,
    input  wire logic [1:0]       speed_i,
    output logic      [LVL_W-1:0] level_o
);
    localparam logic [LVL_W-1:0] LVL_MAX = '1;

    cad_ramp_st_t     state_reg;
    cad_ramp_st_t     state_next;
    logic [LVL_W-1:0] lvl_reg;
    logic [LVL_W-1:0] lvl_next;
    logic [15:0]      cnt_reg;
    logic [15:0]      cnt_next;
    logic [15:0]      lim;
    logic             outer;

    always_comb begin
        case (speed_i)
            2'b01:   lim = 16'(`CAD_RAMP_FAST_CYC - 1);
            2'b10:   lim = 16'(`CAD_RAMP_MED_CYC - 1);
            default: lim = 16'(`CAD_RAMP_SLOW_CYC - 1);
        endcase
        // Slower steps near both ends give the S shape
        outer = (lvl_reg[LVL_W-1 -: 2] == 2'b00) || (lvl_reg[LVL_W-1 -: 2] == 2'b11);
        if (outer) begin
            lim = {lim[14:0], 1'b1};
        end
        state_next = state_reg;
        lvl_next   = lvl_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            RAMP_HOLD: begin
                cnt_next = 16'h0000;
                if (speed_i == 2'b00) begin
                    lvl_next = on_i ? LVL_MAX : '0;
                end else if (on_i && lvl_reg != LVL_MAX) begin
                    state_next = RAMP_RISE;
                end else if (!on_i && lvl_reg != '0) begin
                    state_next = RAMP_FALL;
                end
            end
            default: begin
                if (speed_i == 2'b00 || (on_i != (state_reg == RAMP_RISE))) begin
                    state_next = RAMP_HOLD;
                end else if (cnt_reg >= lim) begin
                    cnt_next = 16'h0000;
                    if (state_reg == RAMP_RISE) begin
                        lvl_next = lvl_reg + 1'b1;
                    end else begin
                        lvl_next = lvl_reg - 1'b1;
                    end
                    if (lvl_next == LVL_MAX || lvl_next == '0) begin
                        state_next = RAMP_HOLD;
                    end
                end else begin
                    cnt_next = cnt_reg + 16'h0001;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= RAMP_HOLD;
            lvl_reg   <= '0;
            cnt_reg   <= 16'h0000;
        end else begin
            state_reg <= state_next;
            lvl_reg   <= lvl_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign level_o = lvl_reg;

    chk_ramp_one_step: assert property (@(posedge clock_i) disable iff (rst_i)
        (speed_i != 2'b00) |=> (level_o == $past(level_o))
            || (level_o == LVL_W'($past(level_o) + 1'b1))
            || (level_o == LVL_W'($past(level_o) - 1'b1)))
        else $error("ramp level jumped by more than one step");

    chk_ramp_bypass: assert property (@(posedge clock_i) disable iff (rst_i)
        (speed_i == 2'b00 && state_reg == RAMP_HOLD && on_i) |=> level_o == LVL_MAX)
        else $error("no-ramp setting did not step the level");
endmodule

// *** cad_ctrl.sv ***
// Accessory detect control: bus slave, sensing, status and interrupt
`timescale 1ns/1ps
`include "cad_map.svh"
module cad_ctrl
    import cad_pkg::*;
#(
    parameter int SLOW_CYC = `CAD_SLOW_CYC,
    parameter int LVL_W    = 8
) (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             hsel_i,
    input  wire logic [31:0]      haddr_i,
    input  wire logic [1:0]       htrans_i,
    input  wire logic             hwrite_i,
    input  wire logic [2:0]       hsize_i,
    input  wire logic [31:0]      hwdata_i,
    input  wire logic             hready_i,
    output logic      [31:0]      hrdata_o,
    output logic                  hreadyout_o,
    output logic                  hresp_o,
    input  wire logic             jack_left_cmp_i,
    input  wire logic             jack_right_cmp_i,
    input  wire logic             mic_plug_cmp_i,
    input  wire logic             mic_short_cmp_i,
    output logic                  jack_sense_left_en_o,
    output logic                  jack_sense_right_en_o,
    output logic                  mic_sense_en_o,
    output logic      [2:0]       mic_plug_threshold_o,
    output logic      [1:0]       mic_short_threshold_o,
    output logic                  mid_rail_string_en_o,
    output logic      [1:0]       mid_rail_sel_o,
    output logic      [LVL_W-1:0] mid_rail_level_o,
    output logic                  irq_o
);
    logic        aphase;
    logic [7:0]  idx_a;
    logic [15:0] wd;
    logic [15:0] rd;
    logic        wr_pend_reg;
    logic        wr_pend_next;
    logic [7:0]  idx_reg;
    logic [7:0]  idx_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic        hready_reg;
    logic [15:0] pwr_reg;
    logic [15:0] pwr_next;
    logic [15:0] micb_reg;
    logic [15:0] micb_next;
    logic [15:0] jack_reg;
    logic [15:0] jack_next;
    logic [15:0] apop_reg;
    logic [15:0] apop_next;
    logic [15:0] cfg_reg;
    logic [15:0] cfg_next;
    logic        mic_en_reg;
    logic        mic_en_next;
    logic [3:0]  msk_reg;
    logic [3:0]  msk_next;
    logic [3:0]  sts_reg;
    logic [3:0]  sts_next;
    logic [3:0]  w1c;
    logic        irq_reg;
    logic        irq_next;
    logic [15:0] tick_cnt_reg;
    logic [15:0] tick_cnt_next;
    logic        tick_reg;
    logic        tick_next;
    cad_sense_t  cmp_raw;
    cad_sense_t  sense_sync;
    cad_sense_t  sense_reg;
    cad_sense_t  sense_next;
    cad_sense_t  ev;

    assign cmp_raw = '{mic_short: mic_short_cmp_i, mic_plug: mic_plug_cmp_i,
                       jack_r: jack_right_cmp_i, jack_l: jack_left_cmp_i};

    // Comparator outputs cross in before any flag logic sees them
    cad_sync u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .d_i     (cmp_raw),
        .q_o     (sense_sync)
    );

    cad_ramp #(
        .LVL_W (LVL_W)
    ) u_ramp (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .on_i    (pwr_reg[`CAD_STR_BIT] && pwr_reg[`CAD_SEL_HI:`CAD_SEL_LO] != 2'b00),
        .speed_i (apop_reg[`CAD_APOP_HI:`CAD_APOP_LO]),
        .level_o (mid_rail_level_o)
    );

    // Bus: zero wait states, write data applied in the data phase
    always_comb begin
        aphase       = hsel_i && htrans_i[1] && hready_i;
        idx_a        = haddr_i[9:2];
        wd           = hwdata_i[15:0];
        wr_pend_next = aphase && hwrite_i;
        idx_next     = aphase ? idx_a : idx_reg;
        pwr_next     = pwr_reg;
        micb_next    = micb_reg;
        jack_next    = jack_reg;
        apop_next    = apop_reg;
        cfg_next     = cfg_reg;
        mic_en_next  = mic_en_reg;
        msk_next     = msk_reg;
        w1c          = 4'h0;
        if (wr_pend_reg) begin
            if (idx_reg == `CAD_IDX_PWR) begin
                pwr_next    = wd & `CAD_PWR_WMASK;
                mic_en_next = wd[`CAD_PWR_MIC_BIT];
            end else if (idx_reg == `CAD_IDX_MICB) begin
                micb_next   = wd & `CAD_MICB_WMASK;
                mic_en_next = wd[`CAD_MICB_MIC_BIT];
            end else if (idx_reg == `CAD_IDX_JACK) begin
                jack_next = wd & `CAD_JACK_WMASK;
            end else if (idx_reg == `CAD_IDX_APOP) begin
                apop_next = wd & `CAD_APOP_WMASK;
            end else if (idx_reg == `CAD_IDX_STS) begin
                w1c = wd[3:0];
            end else if (idx_reg == `CAD_IDX_MSK) begin
                msk_next = wd[3:0];
            end else if (idx_reg == `CAD_IDX_CFG) begin
                cfg_next = wd & `CAD_CFG_WMASK;
            end
        end
        // Read data is sampled in the address phase; no back-to-back write hazard
        // since the master idles between single transfers
        rd = 16'h0000;
        if (idx_a == `CAD_IDX_PWR) begin
            rd = pwr_reg | ({15'h0000, mic_en_reg} << `CAD_PWR_MIC_BIT);
        end else if (idx_a == `CAD_IDX_MICB) begin
            rd = micb_reg | ({15'h0000, mic_en_reg} << `CAD_MICB_MIC_BIT);
        end else if (idx_a == `CAD_IDX_JACK) begin
            rd = jack_reg;
        end else if (idx_a == `CAD_IDX_APOP) begin
            rd = apop_reg;
        end else if (idx_a == `CAD_IDX_STS) begin
            rd = {12'h000, sts_reg};
        end else if (idx_a == `CAD_IDX_MSK) begin
            rd = {12'h000, msk_reg};
        end else if (idx_a == `CAD_IDX_RAW) begin
            rd = {12'h000, sense_reg};
        end else if (idx_a == `CAD_IDX_CFG) begin
            rd = cfg_reg;
        end
        hrdata_next = (aphase && !hwrite_i) ? {16'h0000, rd} : 32'h0000_0000;
    end

    // Slow clock tick; nothing is evaluated while it is stopped
    always_comb begin
        if (!cfg_reg[`CAD_CFG_SLOW_BIT]) begin
            tick_cnt_next = 16'h0000;
            tick_next     = 1'b0;
        end else if (tick_cnt_reg == 16'(SLOW_CYC - 1)) begin
            tick_cnt_next = 16'h0000;
            tick_next     = 1'b1;
        end else begin
            tick_cnt_next = tick_cnt_reg + 16'h0001;
            tick_next     = 1'b0;
        end
    end

    // Sensing, events and sticky status
    always_comb begin
        sense_next = sense_reg;
        if (tick_reg) begin
            sense_next.jack_l    = jack_reg[`CAD_JACK_L_BIT] && sense_sync.jack_l;
            sense_next.jack_r    = jack_reg[`CAD_JACK_R_BIT] && sense_sync.jack_r;
            sense_next.mic_plug  = mic_en_reg && sense_sync.mic_plug;
            sense_next.mic_short = mic_en_reg && sense_sync.mic_short;
        end
        ev           = '0;
        // Either jack edge reports, so jack status follows insert and removal; mic flags set on rising edges only
        ev.jack_l    = tick_reg && jack_reg[`CAD_JACK_L_BIT]
                       && (sense_next.jack_l != sense_reg.jack_l);
        ev.jack_r    = tick_reg && jack_reg[`CAD_JACK_R_BIT]
                       && (sense_next.jack_r != sense_reg.jack_r);
        ev.mic_plug  = sense_next.mic_plug && !sense_reg.mic_plug;
        ev.mic_short = sense_next.mic_short && !sense_reg.mic_short;
        // Set wins over a same-cycle clear
        sts_next = (sts_reg & ~w1c) | ev;
        irq_next = |(sts_next & msk_next);
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend_reg  <= 1'b0;
            idx_reg      <= 8'h00;
            hrdata_reg   <= 32'h0000_0000;
            hready_reg   <= 1'b1;
            pwr_reg      <= `CAD_RST_REG;
            micb_reg     <= `CAD_RST_REG;
            jack_reg     <= `CAD_RST_REG;
            apop_reg     <= `CAD_RST_REG;
            cfg_reg      <= `CAD_RST_REG;
            mic_en_reg   <= 1'b0;
            msk_reg      <= 4'h0;
            sts_reg      <= 4'h0;
            irq_reg      <= 1'b0;
            tick_cnt_reg <= 16'h0000;
            tick_reg     <= 1'b0;
            sense_reg    <= '0;
        end else begin
            wr_pend_reg  <= wr_pend_next;
            idx_reg      <= idx_next;
            hrdata_reg   <= hrdata_next;
            hready_reg   <= 1'b1;
            pwr_reg      <= pwr_next;
            micb_reg     <= micb_next;
            jack_reg     <= jack_next;
            apop_reg     <= apop_next;
            cfg_reg      <= cfg_next;
            mic_en_reg   <= mic_en_next;
            msk_reg      <= msk_next;
            sts_reg      <= sts_next;
            irq_reg      <= irq_next;
            tick_cnt_reg <= tick_cnt_next;
            tick_reg     <= tick_next;
            sense_reg    <= sense_next;
        end
    end

    assign hrdata_o              = hrdata_reg;
    assign hreadyout_o           = hready_reg;
    assign hresp_o               = 1'b0;
    assign jack_sense_left_en_o  = jack_reg[`CAD_JACK_L_BIT];
    assign jack_sense_right_en_o = jack_reg[`CAD_JACK_R_BIT];
    assign mic_sense_en_o        = mic_en_reg;
    assign mic_plug_threshold_o  = micb_reg[`CAD_PLUG_HI:`CAD_PLUG_LO];
    assign mic_short_threshold_o = micb_reg[`CAD_SHORT_HI:`CAD_SHORT_LO];
    assign mid_rail_string_en_o  = pwr_reg[`CAD_STR_BIT];
    assign mid_rail_sel_o        = pwr_reg[`CAD_SEL_HI:`CAD_SEL_LO];
    assign irq_o                 = irq_reg;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    chk_jack_left_en: assert property (
        (wr_pend_reg && idx_reg == `CAD_IDX_JACK) |=>
            jack_sense_left_en_o == $past(hwdata_i[`CAD_JACK_L_BIT]))
        else $error("left jack enable did not follow write");

    chk_jack_right_en: assert property (
        (wr_pend_reg && idx_reg == `CAD_IDX_JACK) |=>
            jack_sense_right_en_o == $past(hwdata_i[`CAD_JACK_R_BIT]))
        else $error("right jack enable did not follow write");

    chk_jack_status: assert property (
        $rose(sts_reg[0]) |-> $past(jack_reg[`CAD_JACK_L_BIT]) && $past(tick_reg))
        else $error("left jack status set while sensing disabled");

    chk_slow_gate: assert property (
        !cfg_reg[`CAD_CFG_SLOW_BIT] |=> !tick_reg ##1 $stable(sense_reg))
        else $error("sensing evaluated with slow clock stopped");

    chk_mic_present: assert property (
        $rose(sts_reg[2]) |-> $past(mic_en_reg) && $past(tick_reg))
        else $error("mic present set without enabled sensing");

    chk_mic_short: assert property (
        (tick_reg && mic_en_reg && sense_sync.mic_short && !sense_reg.mic_short)
            |=> sts_reg[3] && irq_o == msk_reg[3] || irq_o)
        else $error("mic short event not flagged");

    chk_mic_en_alias: assert property (
        (wr_pend_reg && idx_reg == `CAD_IDX_MICB) |=>
            mic_sense_en_o == $past(hwdata_i[`CAD_MICB_MIC_BIT]))
        else $error("mic enable alias did not follow write");

    chk_thresholds: assert property (
        (wr_pend_reg && idx_reg == `CAD_IDX_MICB) |=>
            mic_plug_threshold_o == $past(hwdata_i[`CAD_PLUG_HI:`CAD_PLUG_LO])
            && mic_short_threshold_o == $past(hwdata_i[`CAD_SHORT_HI:`CAD_SHORT_LO]))
        else $error("mic thresholds did not follow write");

    chk_mid_rail: assert property (
        (wr_pend_reg && idx_reg == `CAD_IDX_PWR) |=>
            mid_rail_string_en_o == $past(hwdata_i[`CAD_STR_BIT])
            && mid_rail_sel_o == $past(hwdata_i[`CAD_SEL_HI:`CAD_SEL_LO]))
        else $error("mid-rail controls did not follow write");

    chk_sync_path: assert property (
        (sense_reg != $past(sense_reg)) |-> $past(tick_reg))
        else $error("sense state changed off a slow tick");
endmodule

// *** codec_accessory_detect_ctrl_tb.sv ***
// Self-checking bench for the accessory detect control block
`timescale 1ns/1ps
`include "cad_map.svh"
module codec_accessory_detect_ctrl_tb;
    import cad_pkg::*;
    localparam logic [31:0] A_PWR  = {22'h0, `CAD_IDX_PWR, 2'b00};
    localparam logic [31:0] A_MICB = {22'h0, `CAD_IDX_MICB, 2'b00};
    localparam logic [31:0] A_JACK = {22'h0, `CAD_IDX_JACK, 2'b00};
    localparam logic [31:0] A_APOP = {22'h0, `CAD_IDX_APOP, 2'b00};
    localparam logic [31:0] A_STS  = {22'h0, `CAD_IDX_STS, 2'b00};
    localparam logic [31:0] A_MSK  = {22'h0, `CAD_IDX_MSK, 2'b00};
    localparam logic [31:0] A_CFG  = {22'h0, `CAD_IDX_CFG, 2'b00};
    localparam logic [31:0] A_RAW  = {22'h0, `CAD_IDX_RAW, 2'b00};
    localparam logic [31:0] A_NONE = 32'h0000_0100;
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0]  htrans_i = 2'b00;
    logic        hwrite_i = 1'b0;
    logic [2:0]  hsize_i = 3'b010;
    logic [31:0] hwdata_i = 32'h0;
    wire         hready_i;
    logic [31:0] hrdata_o;
    logic        hreadyout_o;
    logic        hresp_o;
    logic        jl_cmp = 1'b0;
    logic        jr_cmp = 1'b0;
    logic        plug_cmp = 1'b0;
    logic        short_cmp = 1'b0;
    logic        jl_en, jr_en, mic_en, str_en, irq_o;
    logic [2:0]  plug_thr;
    logic [1:0]  short_thr, sel;
    logic [7:0]  level;
    int          n_fail = 0;
    int          compares = 0;
    assign hready_i = hreadyout_o;
    always #25 clock_i = ~clock_i;
    // Short slow tick keeps the sensing scenarios brief
    cad_ctrl #(.SLOW_CYC(4), .LVL_W(8)) i_dut (
        .clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .jack_left_cmp_i(jl_cmp),
        .jack_right_cmp_i(jr_cmp), .mic_plug_cmp_i(plug_cmp),
        .mic_short_cmp_i(short_cmp), .jack_sense_left_en_o(jl_en),
        .jack_sense_right_en_o(jr_en), .mic_sense_en_o(mic_en),
        .mic_plug_threshold_o(plug_thr), .mic_short_threshold_o(short_thr),
        .mid_rail_string_en_o(str_en), .mid_rail_sel_o(sel),
        .mid_rail_level_o(level), .irq_o(irq_o));
    task end_of_test;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Ready and read data taken at the rising edge, before it updates them
    task wait_rdy(output logic [31:0] rd);
        int i;
        i = 0;
        @(posedge clock_i);
        while (hreadyout_o !== 1'b1 && i < 50) begin
            i++;
            @(posedge clock_i);
        end
        if (i == 50) begin
            n_fail++;
            end_of_test();
        end
        rd = hrdata_o;
    endtask
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
             output logic [31:0] rd);
        logic [31:0] x;
        @(posedge clock_i);
        hsel_i <= 1'b1;
        haddr_i <= a;
        htrans_i <= 2'b10;
        hwrite_i <= wr;
        wait_rdy(x);
        hsel_i <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        wait_rdy(rd);
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
        // Written register only settles after the data phase edge
        @(posedge clock_i);
    endtask
    task rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(x, exp);
    endtask
    task wait_cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task wait_irq(input logic lvl);
        int i;
        for (i = 0; i < 200 && irq_o !== lvl; i++) @(posedge clock_i);
        check({31'h0, irq_o}, {31'h0, lvl});
        if (i == 200) end_of_test();
    endtask
    task t_reset;
        rd_chk(A_PWR, 32'h0);
        rd_chk(A_MICB, 32'h0);
        rd_chk(A_JACK, 32'h0);
        rd_chk(A_NONE, 32'h0);
        check({jl_en, jr_en, mic_en, str_en, sel, level}, 32'h0);
        $display("t_reset done");
    endtask
    task t_fields;
        int c;
        wr(A_JACK, 32'h0000_ffff);
        rd_chk(A_JACK, 32'h0000_c000);
        check({jl_en, jr_en}, 32'h3);
        wr(A_PWR, 32'h0000_0100);
        rd_chk(A_MICB, 32'h0000_0080);
        for (c = 0; c < 4; c++) begin
            wr(A_PWR, 32'h4 | c);
            check({mic_en, str_en, sel}, 32'h4 | c);
        end
        for (c = 0; c < 8; c++) begin
            wr(A_MICB, (c << 2) | (c & 3));
            check({mic_en, plug_thr, short_thr}, (c << 2) | (c & 3));
        end
        rd_chk(A_PWR, 32'h0000_0007);
        wr(A_PWR, 32'h0);
        wr(A_JACK, 32'h0);
        $display("t_fields done");
    endtask
    task t_jack;
        wr(A_CFG, 32'h1);
        wr(A_MSK, 32'hf);
        wr(A_JACK, 32'h8000);
        jl_cmp <= 1'b1;
        wait_irq(1'b1);
        rd_chk(A_STS, 32'h1);
        rd_chk(A_RAW, 32'h1);
        wr(A_STS, 32'hf);
        wait_irq(1'b0);
        jr_cmp <= 1'b1;
        wait_cyc(40);
        rd_chk(A_STS, 32'h0);
        // Removal while the slow clock is stopped is only seen once it runs
        wr(A_CFG, 32'h0);
        jl_cmp <= 1'b0;
        wait_cyc(40);
        rd_chk(A_STS, 32'h0);
        wr(A_CFG, 32'h1);
        wait_irq(1'b1);
        rd_chk(A_STS, 32'h1);
        wr(A_STS, 32'hf);
        wr(A_JACK, 32'h4000);
        wait_irq(1'b1);
        rd_chk(A_STS, 32'h2);
        wr(A_STS, 32'hf);
        wr(A_JACK, 32'h0);
        $display("t_jack done");
    endtask
    task t_mic;
        wr(A_PWR, 32'h0000_0100);
        plug_cmp <= 1'b1;
        wait_irq(1'b1);
        rd_chk(A_STS, 32'h4);
        wr(A_STS, 32'hf);
        wr(A_MSK, 32'h0);
        short_cmp <= 1'b1;
        wait_cyc(40);
        rd_chk(A_STS, 32'h8);
        check({31'h0, irq_o}, 32'h0);
        wr(A_MSK, 32'hf);
        wait_irq(1'b1);
        plug_cmp <= 1'b0;
        short_cmp <= 1'b0;
        wait_cyc(40);
        wr(A_STS, 32'hf);
        wr(A_CFG, 32'h0);
        plug_cmp <= 1'b1;
        wait_cyc(40);
        rd_chk(A_STS, 32'h0);
        wr(A_CFG, 32'h1);
        wait_irq(1'b1);
        rd_chk(A_STS, 32'h4);
        wr(A_STS, 32'hf);
        wr(A_PWR, 32'h0);
        $display("t_mic done");
    endtask
    task t_ramp;
        int n;
        wr(A_APOP, 32'h0);
        wr(A_PWR, 32'h5);
        wait_cyc(3);
        check({24'h0, level}, 32'hff);
        wr(A_APOP, 32'h0100);
        wr(A_PWR, 32'h1);
        wait_cyc(5);
        check({31'h0, level > 8'hf0}, 32'h1);
        for (n = 0; n < 20000 && level !== 8'h00; n++) @(posedge clock_i);
        check({31'h0, n > 5000 && n < 20000}, 32'h1);
        // Medium speed, active codec on the 50k string
        wr(A_APOP, 32'h0200);
        wr(A_PWR, 32'h6);
        check({30'h0, sel}, 32'h2);
        wait_cyc(400);
        check({31'h0, level > 8'h00 && level < 8'h04}, 32'h1);
        // Standby keeps the reference on the 300k string
        wr(A_PWR, 32'h5);
        check({30'h0, sel}, 32'h1);
        $display("t_ramp done");
    endtask
    initial begin
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        check({31'h0, hresp_o}, 32'h0);
        t_reset();
        t_fields();
        t_jack();
        t_mic();
        t_ramp();
        end_of_test();
    end
endmodule
